// ### conv_model.sv
// behavioural converters and window comparators for four supplies
`timescale 1ns/1ps
module conv_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // open-drain enable wires
  input  wire logic [3:0]  sup_en_out,
  input  wire logic [3:0]  sup_en_oe_n,
  output logic      [3:0]  sup_en_in,
  // comparator results
  output logic      [3:0]  uv_above,
  output logic      [3:0]  ov_below,
  // ramp time and fault injection
  input  wire logic [15:0] ramp_cyc,
  input  wire logic [3:0]  stuck,
  input  wire logic [3:0]  over
);
  int unsigned age [4];

  // ==========================================
  // wire level: a pull-up holds a released enable high
  assign sup_en_in = sup_en_oe_n | sup_en_out;

  // a rail whose wire is pulled low needs ramp_cyc + 1 cycles; a stuck rail never arrives
  always @(posedge ref_clk or negedge reset_n)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!reset_n || sup_en_in[i])
        age[i] <= 0;
      else if (age[i] < 65535)
        age[i] <= age[i] + 1;
    end
  end

  // comparators: in window needs both above under-limit and below over-limit
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      uv_above[i] = (age[i] > ramp_cyc) && !stuck[i];
      ov_below[i] = !over[i];
    end
  end
endmodule

// ### power_sequencer.sv
// sequencer for four board supplies with window monitoring
//
// Contract
// [RULE1] a no-sequencing group has all its enables asserted in one cycle
// [RULE2] power good rises only when every supply is in window
// [RULE3] in window means above under-voltage and below over-voltage limit
// [RULE4] closed loop: next enable only after previous supply in window
// [RULE5] time based: wait programmed delay, ignore window of earlier supply
// [RULE6] closed loop with delay: wait for window, then delay, then enable
// [RULE7] timeout mode: supply not in window before timer ends is a fault
// [RULE8] watchdog: all supplies in window before it expires, else fault
// [RULE9] abort turn-on at once when a supply fails its allowed period
// [RULE10] comparator results are evaluated live during the whole sequence
// [RULE11] power-down removes enables one by one in reverse order
// [RULE12] enables are open-drain; pulling low enables the converter
// [RULE13] delay between steps is programmable without logic change
// [RULE14] any mode per supply; timers span 32 us to 2 s
// [RULE15] fault drops all enables, raises failure, keeps power good low
// [RULE16] after completion or failure hold until restart, then from supply one
// [RULE17] after reset enables off, power good low, failure cleared
// [RULE18] comparator inputs pass two flip-flops before use
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module power_sequencer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // open-drain converter enables, active low on the wire
  input  wire logic [3:0]  sup_en_in,
  output logic      [3:0]  sup_en_out,
  output logic      [3:0]  sup_en_oe_n,
  // window comparators, asynchronous
  input  wire logic [3:0]  uv_above,
  input  wire logic [3:0]  ov_below,
  // system control and status
  input  wire logic        restart_req,
  input  wire logic        shutdown_req,
  output logic             power_good,
  output logic             seq_fail,
  output logic             irq
);
  typedef struct packed {
    seq_pkg::fsm_t fsm;
    logic [1:0]    idx;
    logic [3:0]    en;
    logic          pgood;
    logic          fail;
    logic          wd_en;
    logic          wd_run;
    logic [11:0]   mode;
    logic [15:0]   dly;
    logic [15:0]   tmo;
    logic [15:0]   wdt;
    logic [2:0]    ev;
    logic [2:0]    mask;
    logic [31:0]   rdata;
  } state_t;
  state_t r;
  state_t next_r;

  timer_if step_if ();
  timer_if wd_if ();

  logic [3:0]     uv_s, ov_s, in_win, grp;
  logic [1:0]     last;
  seq_pkg::mode_t cur_mode;
  logic           all_win, grp_win, seq_on, open_grp;
  logic           restart, shut, adv, fault, go, down;
  logic [2:0]     ev_set, ev_clr;
  logic           t_go, w_go;
  logic [15:0]    t_val;

  // ==========================================
  // comparator inputs
  // metastability is settled before any decision looks at a result
  sync2 #(.W(4)) u_sync_uv (.ref_clk(ref_clk), .reset_n(reset_n), .d(uv_above), .q(uv_s)); // [RULE18]
  sync2 #(.W(4)) u_sync_ov (.ref_clk(ref_clk), .reset_n(reset_n), .d(ov_below), .q(ov_s)); // [RULE18]

  // per supply window, read live in every state
  for (genvar i = 0; i < seq_pkg::N_SUP; i++)
  begin : g_win
    assign in_win[i] = uv_s[i] & ov_s[i]; // [RULE3] [RULE10]
  end
  assign all_win = &in_win;

  // ==========================================
  // timers
  step_timer u_step (.ref_clk(ref_clk), .reset_n(reset_n), .t(step_if));
  step_timer u_wdog (.ref_clk(ref_clk), .reset_n(reset_n), .t(wd_if));
  // starts are combinational so a stale expiry is never seen after a start
  assign step_if.start = t_go;
  assign step_if.load  = t_val;
  assign wd_if.start   = w_go;
  assign wd_if.load    = r.wdt;

  // ==========================================
  // step group: leading no-sequencing supplies join the next one
  always_comb
  begin
    grp = 4'h0;
    last = r.idx;
    open_grp = 1'b1;
    for (int j = 0; j < seq_pkg::N_SUP; j++)
    begin
      if (j >= int'(r.idx) && open_grp)
      begin
        grp[j] = 1'b1; // [RULE1]
        last = 2'(j);
        if (seq_pkg::mode_t'(r.mode[3*j +: 3]) != seq_pkg::M_NONE)
          open_grp = 1'b0;
      end
    end
    cur_mode = seq_pkg::mode_t'(r.mode[3*last +: 3]); // [RULE14]
    grp_win = &(in_win | ~grp); // [RULE10]
  end

  // ==========================================
  // sequencer and register file
  always_comb
  begin
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    ev_set = 3'h0;
    ev_clr = 3'h0;
    t_go = 1'b0;
    t_val = r.dly;
    w_go = 1'b0;
    adv = 1'b0;
    fault = 1'b0;
    go = 1'b0;
    down = 1'b0;
    restart = restart_req;
    shut = shutdown_req;
    // register writes; restart and shutdown bits are pulses
    if (reg_wr)
    begin
      case (reg_addr)
        seq_pkg::A_CTRL:
        begin
          next_r.wd_en = reg_wdata[seq_pkg::C_WDEN];
          restart = restart | reg_wdata[seq_pkg::C_RESTART];
          shut = shut | reg_wdata[seq_pkg::C_SHUT];
        end
        seq_pkg::A_MODE: next_r.mode = reg_wdata[11:0]; // [RULE14]
        seq_pkg::A_DLY:  next_r.dly = reg_wdata[15:0]; // [RULE13]
        seq_pkg::A_TMO:  next_r.tmo = reg_wdata[15:0];
        seq_pkg::A_WDT:  next_r.wdt = reg_wdata[15:0];
        seq_pkg::A_EVT:  ev_clr = reg_wdata[2:0];
        seq_pkg::A_MASK: next_r.mask = reg_wdata[2:0];
        default: ;
      endcase
    end
    seq_on = (r.fsm == seq_pkg::F_STEP) || (r.fsm == seq_pkg::F_WIN) ||
             (r.fsm == seq_pkg::F_DLY) || (r.fsm == seq_pkg::F_CHECK);
    case (r.fsm)
      seq_pkg::F_IDLE:
        go = restart;
      seq_pkg::F_STEP:
      begin
        next_r.en = r.en | grp; // [RULE1]
        case (cur_mode)
          seq_pkg::M_NONE:
            adv = 1'b1; // [RULE1]
          seq_pkg::M_TIMED:
          begin
            t_go = 1'b1; // [RULE5]
            next_r.fsm = seq_pkg::F_DLY;
          end
          seq_pkg::M_TMO:
          begin
            t_go = 1'b1; // [RULE7]
            t_val = r.tmo;
            next_r.fsm = seq_pkg::F_WIN;
          end
          default:
            next_r.fsm = seq_pkg::F_WIN;
        endcase
      end
      seq_pkg::F_WIN:
      begin
        if (grp_win)
        begin
          if (cur_mode == seq_pkg::M_CLDLY)
          begin
            t_go = 1'b1; // [RULE6]
            next_r.fsm = seq_pkg::F_DLY;
          end
          else
            adv = 1'b1; // [RULE4]
        end
        else if (cur_mode == seq_pkg::M_TMO && step_if.expired)
          fault = 1'b1; // [RULE7] [RULE9]
      end
      seq_pkg::F_DLY:
        adv = step_if.expired; // [RULE5] [RULE6]
      seq_pkg::F_CHECK:
      begin
        if (all_win)
        begin
          next_r.fsm = seq_pkg::F_GOOD;
          next_r.pgood = 1'b1; // [RULE2]
          next_r.wd_run = 1'b0;
          ev_set[seq_pkg::E_PGOOD] = 1'b1;
        end
      end
      seq_pkg::F_GOOD:
      begin
        next_r.pgood = all_win; // [RULE2]
        go = restart; // [RULE16]
        down = shut & ~restart;
      end
      seq_pkg::F_DOWN:
      begin
        // one enable per step delay, highest supply first
        if (step_if.expired)
        begin
          if (r.en == 4'h0)
          begin
            next_r.fsm = seq_pkg::F_OFF;
            ev_set[seq_pkg::E_DOWN] = 1'b1;
          end
          else
          begin
            t_go = 1'b1;
            for (int k = 0; k < seq_pkg::N_SUP; k++)
              if (r.en[k] && (r.en >> (k + 1)) == 4'h0)
                next_r.en[k] = 1'b0; // [RULE11]
          end
        end
      end
      seq_pkg::F_FAIL,
      seq_pkg::F_OFF:
        go = restart; // [RULE16]
      default:
        next_r.fsm = seq_pkg::F_IDLE;
    endcase
    // step done: next group or final check
    if (adv)
    begin
      if (last == 2'(seq_pkg::N_SUP - 1))
        next_r.fsm = seq_pkg::F_CHECK;
      else
      begin
        next_r.idx = last + 2'h1;
        next_r.fsm = seq_pkg::F_STEP;
      end
    end
    // the watchdog covers the whole turn-on
    if (seq_on && r.wd_run && wd_if.expired)
      fault = 1'b1; // [RULE8]
    if (seq_on && shut)
      down = 1'b1;
    if (down)
    begin
      next_r.fsm = seq_pkg::F_DOWN;
      next_r.pgood = 1'b0;
      next_r.wd_run = 1'b0;
      next_r.en = r.en;
      t_go = 1'b1;
      t_val = r.dly;
    end
    if (fault)
    begin
      next_r.fsm = seq_pkg::F_FAIL; // [RULE9]
      next_r.en = 4'h0; // [RULE15]
      next_r.fail = 1'b1;
      next_r.pgood = 1'b0;
      next_r.wd_run = 1'b0;
      ev_set[seq_pkg::E_FAIL] = 1'b1;
    end
    if (go)
    begin
      next_r.fsm = seq_pkg::F_STEP; // [RULE16]
      next_r.idx = 2'h0;
      next_r.en = 4'h0;
      next_r.fail = 1'b0;
      next_r.pgood = 1'b0;
      next_r.wd_run = r.wd_en;
      w_go = r.wd_en; // [RULE8]
    end
    // a new event wins over a clear in the same cycle
    next_r.ev = (r.ev & ~ev_clr) | ev_set;
    if (reg_rd)
    begin
      case (reg_addr)
        seq_pkg::A_CTRL: next_r.rdata = {29'h0, r.wd_en, 2'h0};
        seq_pkg::A_MODE: next_r.rdata = {20'h0, r.mode};
        seq_pkg::A_DLY:  next_r.rdata = {16'h0, r.dly};
        seq_pkg::A_TMO:  next_r.rdata = {16'h0, r.tmo};
        seq_pkg::A_WDT:  next_r.rdata = {16'h0, r.wdt};
        seq_pkg::A_STAT: next_r.rdata = {14'h0, ~sup_en_in, r.fail, r.pgood,
                                         r.fsm, in_win, r.en};
        seq_pkg::A_EVT:  next_r.rdata = {29'h0, r.ev};
        seq_pkg::A_MASK: next_r.rdata = {29'h0, r.mask};
        default:         next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // reset holds everything off until a restart request
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0; // [RULE17]
      r.mode <= seq_pkg::R_MODE;
      r.dly <= seq_pkg::R_DLY;
      r.tmo <= seq_pkg::R_TMO;
      r.wdt <= seq_pkg::R_WDT;
    end
    else
      r <= next_r;
  end

  // ==========================================
  // outputs
  // the pad only ever pulls low; release lets the converter stay off
  assign sup_en_out  = 4'h0; // [RULE12]
  assign sup_en_oe_n = ~r.en; // [RULE12]
  assign power_good  = r.pgood;
  assign seq_fail    = r.fail;
  assign irq         = |(r.ev & r.mask);
  assign reg_rdata   = r.rdata;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_tmo_miss;
    r.fsm == seq_pkg::F_WIN && cur_mode == seq_pkg::M_TMO && !grp_win && step_if.expired;
  endsequence

  a_group_enable: assert property ( // [RULE1]
    r.fsm == seq_pkg::F_STEP && !fault && !down |=> (r.en & $past(grp)) == $past(grp))
    else $error("group enables not asserted together");
  a_pgood_window: assert property ( // [RULE2]
    $rose(power_good) |-> $past(&(uv_s & ov_s)))
    else $error("power good without all supplies in window");
  a_closed_hold: assert property ( // [RULE4]
    r.fsm == seq_pkg::F_WIN && !grp_win && !shut && !fault |=> r.en == $past(r.en))
    else $error("enable advanced before window reached");
  a_delay_hold: assert property ( // [RULE5]
    r.fsm == seq_pkg::F_DLY && !step_if.expired && !shut && !fault |=> r.en == $past(r.en))
    else $error("enable advanced before delay ended");
  a_timeout_fault: assert property ( // [RULE7]
    s_tmo_miss |=> r.fsm == seq_pkg::F_FAIL && seq_fail)
    else $error("timeout did not raise failure");
  a_wdog_fault: assert property ( // [RULE8]
    seq_on && r.wd_run && wd_if.expired |=> r.fsm == seq_pkg::F_FAIL)
    else $error("watchdog expiry ignored");
  a_fail_outputs: assert property ( // [RULE15]
    r.fsm == seq_pkg::F_FAIL |-> sup_en_oe_n == 4'hf && seq_fail && !power_good)
    else $error("fault state with enables or power good");
  a_down_single: assert property ( // [RULE11]
    r.fsm == seq_pkg::F_DOWN |=> $onehot0($past(r.en) & ~r.en) && (r.en & ~$past(r.en)) == 4'h0)
    else $error("power-down removed more than one enable");
  a_fail_hold: assert property ( // [RULE16]
    r.fsm == seq_pkg::F_FAIL && !restart |=> r.fsm == seq_pkg::F_FAIL)
    else $error("failure state left without restart");
endmodule

// ### seq_pkg.sv
// shared constants and types of the supply sequencer
package seq_pkg;
  // ==========================================
  // sizes and timing
  localparam int          N_SUP     = 4;
  localparam int          MODE_W    = 3;
  localparam int          TMR_W     = 16;
  localparam int          CLK_NS    = 40;
  localparam int          TICK_NS   = 32000;
  // least time, so round the tick up to whole cycles
  localparam int          TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0]  TICK_LAST = 10'(TICK_CYC - 1);
  // ==========================================
  // register offsets
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_MODE    = 8'h04;
  localparam logic [7:0]  A_DLY     = 8'h08;
  localparam logic [7:0]  A_TMO     = 8'h0c;
  localparam logic [7:0]  A_WDT     = 8'h10;
  localparam logic [7:0]  A_STAT    = 8'h14;
  localparam logic [7:0]  A_EVT     = 8'h18;
  localparam logic [7:0]  A_MASK    = 8'h1c;
  // ==========================================
  // field positions
  localparam int          C_RESTART = 0;
  localparam int          C_SHUT    = 1;
  localparam int          C_WDEN    = 2;
  localparam int          S_EN      = 0;
  localparam int          S_WIN     = 4;
  localparam int          S_FSM     = 8;
  localparam int          S_PG      = 12;
  localparam int          S_FAIL    = 13;
  localparam int          E_PGOOD   = 0;
  localparam int          E_FAIL    = 1;
  localparam int          E_DOWN    = 2;
  // ==========================================
  // reset values, timers in 32 us ticks
  localparam logic [11:0] R_MODE    = 12'h249;
  localparam logic [15:0] R_DLY     = 16'h0020;
  localparam logic [15:0] R_TMO     = 16'h009c;
  localparam logic [15:0] R_WDT     = 16'h0c35;
  // ==========================================
  // turn-on methods and sequencer states
  typedef enum logic [2:0] {M_NONE = 3'h0, M_CLOSED = 3'h1, M_TIMED = 3'h2,
                            M_CLDLY = 3'h3, M_TMO = 3'h4} mode_t;
  typedef enum logic [3:0] {F_IDLE = 4'h0, F_STEP = 4'h1, F_WIN = 4'h2, F_DLY = 4'h3,
                            F_CHECK = 4'h4, F_GOOD = 4'h5, F_FAIL = 4'h6,
                            F_DOWN = 4'h7, F_OFF = 4'h8} fsm_t;
endpackage

// ### step_timer.sv
// down counter in 32 us ticks, expiry held until the next start
`timescale 1ns/1ps
module step_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  timer_if.tmr     t
);
  typedef struct packed {
    logic [9:0]  pre;
    logic [15:0] cnt;
    logic        run;
    logic        expired;
  } tmr_t;
  tmr_t r;
  tmr_t next_r;
  logic tick;

  // a start realigns the prescaler so the first tick is a full 32 us
  always_comb
  begin
    next_r = r;
    tick = (r.pre == seq_pkg::TICK_LAST);
    next_r.pre = tick ? 10'h000 : r.pre + 10'h001;
    if (t.start)
    begin
      next_r.pre = 10'h000;
      next_r.cnt = t.load;
      next_r.run = 1'b1;
      next_r.expired = 1'b0;
    end
    else if (r.run && tick)
    begin
      if (r.cnt <= 16'h0001)
      begin
        next_r.run = 1'b0;
        next_r.expired = 1'b1;
      end
      else
        next_r.cnt = r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign t.expired = r.expired;
endmodule

// ### sync2.sv
// two flip-flop synchroniser for the comparator results
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r;
  sync_t next_r;

  // the first stage feeds only the second one
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule

// ### test_power_sequencer.sv
// self-checking bench for the supply sequencer
`timescale 1ns/1ps
module test_power_sequencer;
  logic        ref_clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0]  sup_en_in, sup_en_out, sup_en_oe_n, uv_above, ov_below, stuck, over;
  logic        restart_req, shutdown_req, power_good, seq_fail, irq;
  logic [15:0] ramp_cyc;
  int          fails, compares, cyc, n;

  // ==========================================
  // design and far side
  power_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sup_en_in(sup_en_in), .sup_en_out(sup_en_out), .sup_en_oe_n(sup_en_oe_n),
    .uv_above(uv_above), .ov_below(ov_below), .restart_req(restart_req),
    .shutdown_req(shutdown_req), .power_good(power_good), .seq_fail(seq_fail), .irq(irq));
  conv_model i_conv (.ref_clk(ref_clk), .reset_n(reset_n), .sup_en_out(sup_en_out),
    .sup_en_oe_n(sup_en_oe_n), .sup_en_in(sup_en_in), .uv_above(uv_above),
    .ov_below(ov_below), .ramp_cyc(ramp_cyc), .stuck(stuck), .over(over));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================
  // tasks
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write strobe, then one idle edge so the strobe is never set twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // read data stands only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask

  // bounded wait: 0 enables equal v, 1 power good, 2 failure, 3 power good low, 4 any enable
  task automatic wait_for(input int sel, input logic [3:0] v, input int lim);
    n = 0;
    #1;
    while (!((sel == 0 && sup_en_oe_n === v) || (sel == 1 && power_good === 1'b1) ||
             (sel == 2 && seq_fail === 1'b1) || (sel == 3 && power_good === 1'b0) ||
             (sel == 4 && sup_en_oe_n !== 4'hf)) && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(n < lim), 32'h1);
    @(posedge ref_clk);
  endtask

  task automatic cfg(input logic [11:0] m, input logic [15:0] dly, input logic [15:0] wdt,
                     input logic wden);
    wr(8'h04, {20'h0, m});
    wr(8'h08, {16'h0, dly});
    wr(8'h0c, 32'h1);
    wr(8'h10, {16'h0, wdt});
    wr(8'h00, {29'h0, wden, 2'h0});
    wr(8'h1c, 32'h7);
    wr(8'h18, 32'h7);
  endtask

  task automatic restart();
    restart_req <= 1'b1;
    @(posedge ref_clk);
    restart_req <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ==========================================
  // tests
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    restart_req = 1'b0;
    shutdown_req = 1'b0;
    stuck = 4'h0;
    over = 4'h0;
    ramp_cyc = 16'h0064;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    // reset state, reset values, unmapped and read-only places
    chk({sup_en_oe_n, power_good, seq_fail, irq}, 32'h78);
    rd(8'h04, 32'h249);
    rd(8'h08, 32'h20);
    rd(8'h0c, 32'h9c);
    rd(8'h10, 32'hc35);
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    $display("test reset done");
    // closed loop: second enable waits for the first rail to ramp
    cfg(12'h249, 16'h1, 16'h0, 1'b0);
    restart();
    wait_for(0, 4'he, 20);
    wait_for(0, 4'hc, 300);
    chk(32'(n >= 100), 32'h1);
    wait_for(1, 4'h0, 1500);
    chk(sup_en_oe_n, 32'h0);
    rd(8'h14, 32'h3d5ff);
    rd(8'h18, 32'h1);
    chk(irq, 32'h1);
    wr(8'h18, 32'h1);
    chk(irq, 32'h0);
    over <= 4'h2;
    wait_for(3, 4'h0, 20);
    chk(seq_fail, 32'h0);
    over <= 4'h0;
    wait_for(1, 4'h0, 20);
    $display("test closed loop done");
    // power-down releases supplies highest first
    wr(8'h18, 32'h7);
    shutdown_req <= 1'b1;
    @(posedge ref_clk);
    shutdown_req <= 1'b0;
    wait_for(0, 4'h8, 1000);
    wait_for(0, 4'hc, 1000);
    wait_for(0, 4'he, 1000);
    wait_for(0, 4'hf, 1000);
    repeat (900) @(posedge ref_clk);
    rd(8'h18, 32'h4);
    $display("test power down done");
    // no sequencing, restarted and powered down through the control register
    cfg(12'h000, 16'h1, 16'h0, 1'b0);
    wr(8'h00, 32'h1);
    wait_for(4, 4'h0, 20);
    chk(sup_en_oe_n, 32'h0);
    wait_for(1, 4'h0, 300);
    wr(8'h00, 32'h2);
    wait_for(0, 4'hf, 3300);
    repeat (900) @(posedge ref_clk);
    rd(8'h18, 32'h5);
    $display("test no sequencing done");
    // time based with a dead first rail, caught by the watchdog
    stuck <= 4'h1;
    cfg(12'h492, 16'h1, 16'h4, 1'b1);
    restart();
    wait_for(0, 4'he, 20);
    wait_for(0, 4'hc, 1700);
    chk(32'(n >= 790), 32'h1);
    wait_for(2, 4'h0, 4000);
    chk({sup_en_oe_n, power_good}, 32'h1e);
    $display("test watchdog done");
    // closed loop with delay, restarted from failure
    stuck <= 4'h0;
    cfg(12'h6db, 16'h2, 16'h0, 1'b0);
    restart();
    chk(seq_fail, 32'h0);
    wait_for(0, 4'he, 20);
    wait_for(0, 4'hc, 3000);
    chk(32'(n >= 1700), 32'h1);
    chk(32'(n < 2600), 32'h1);
    wait_for(1, 4'h0, 8000);
    $display("test closed loop delay done");
    // timeout mode with the third rail dead
    stuck <= 4'h4;
    cfg(12'h924, 16'h1, 16'h0, 1'b0);
    restart();
    wait_for(0, 4'h8, 400);
    wait_for(2, 4'h0, 1700);
    chk({sup_en_oe_n, power_good}, 32'h1e);
    rd(8'h18, 32'h2);
    chk(irq, 32'h1);
    wr(8'h1c, 32'h0);
    chk(irq, 32'h0);
    wr(8'h18, 32'h2);
    rd(8'h18, 32'h0);
    $display("test timeout done");
    report_and_stop();
  end
endmodule

// ### timer_if.sv
// start, load and expiry of one tick timer
`timescale 1ns/1ps
interface timer_if;
  logic        start;
  logic [15:0] load;
  logic        expired;
  modport ctl (output start, output load, input expired);
  modport tmr (input start, input load, output expired);
endinterface
